// file: logic/ees_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock domain; in_ready drops only when both entries are held.
`timescale 1ns/1ps

module ees_buf2 #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);

   logic [W-1:0] slot0;
   logic [W-1:0] slot1;
   logic [1:0]   cnt;
   logic [W-1:0] next_slot0;
   logic [W-1:0] next_slot1;
   logic [1:0]   next_cnt;
   logic         push;
   logic         pop;

   assign in_ready  = (cnt != 2'h2);
   assign out_valid = (cnt != 2'h0);
   assign out_data  = slot0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_slot0 = slot0;
      next_slot1 = slot1;
      next_cnt   = cnt;
      case ({push, pop})
         2'b10: begin
            if (cnt == 2'h0) begin
               next_slot0 = in_data;
            end else begin
               next_slot1 = in_data;
            end
            next_cnt = cnt + 2'h1;
         end
         2'b01: begin
            next_slot0 = slot1;
            next_cnt   = cnt - 2'h1;
         end
         2'b11: begin
            if (cnt == 2'h1) begin
               next_slot0 = in_data;
            end else begin
               next_slot0 = slot1;
               next_slot1 = in_data;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slot0 <= '0;
         slot1 <= '0;
         cnt   <= 2'h0;
      end else begin
         slot0 <= next_slot0;
         slot1 <= next_slot1;
         cnt   <= next_cnt;
      end
   end

endmodule // ees_buf2

// file: logic/ees_params.svh
// Constants of the two-wire serial EEPROM target: address word layout, sizes and timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef EES_PARAMS_SVH
`define EES_PARAMS_SVH

`define EES_DEV_TYPE      4'ha
`define EES_BYTE_DONE     4'h8
`define EES_MAX_AW        11
`define EES_MEM_BYTES     2048
`define EES_LAT_DEPTH     16
`define EES_BASE_AW       7
`define EES_SIZE_16K      4
`define EES_PAGE8_MASK    11'h007
`define EES_PAGE16_MASK   11'h00f
`define EES_PROG_TIME_MS  5
`define EES_CLK_HZ        10000000
`define EES_SYNC_W        6

`endif

// file: logic/ees_pkg.sv
// Types shared by the EEPROM target and its write buffer.
// Assumes the constant header is on the include path.
`include "ees_params.svh"

package ees_pkg;

   typedef enum {
      ST_IDLE,
      ST_DEV,
      ST_DEV_ACK,
      ST_WADDR,
      ST_WADDR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RACK
   } ees_state_e;

   typedef struct packed {
      logic [`EES_MAX_AW-1:0] addr;
      logic [7:0]             data;
   } ees_wr_word_s;

endpackage

// file: logic/ees_target.sv
// Two-wire serial EEPROM target: bus protocol, address counter, page latch and array.
// Assumes SCL, SDA, the select pins and the protect pin are asynchronous to clk.
`timescale 1ns/1ps
`include "ees_params.svh"

// Notes on behaviour
// - SDA falling while SCL high is a start; detected in any state.
// - SDA rising while SCL high is a stop; ends the current transfer.
// - SDA changes while SCL high are only start or stop, never data.
// - Eight-bit words, MSB first; device pulls SDA low on the ninth clock.
// - Upper four address word bits must equal the fixed device type code.
// - Small sizes compare three address bits against the three select pins.
// - Larger sizes turn low select bits into page bits, the top word address bits.
// - Address word bit eight high means read, low means write.
// - Match is acknowledged low; a mismatch releases SDA and waits for start.
// - Byte write is device word, word address, one data byte, then stop.
// - After a write stop the device ignores the bus for the program time.
// - Page write sends further acknowledged bytes; 8 or 16 byte pages.
// - Writes increment only the page offset bits, wrapping within the page.
// - Address words during programming are not acknowledged until it finishes.
// - Address counter holds last accessed location plus one between transfers.
// - Reads advance across pages and wrap from the last byte to zero.
// - Current read sends the byte at the counter; controller nacks then stops.
// - Random read is a dummy write of the address, repeated start, then read.
// - Each controller acknowledge during a read sends the next byte.
// - Standby after reset and after a stop once programming has finished.
// - Inputs sampled on SCL rising; SDA output changes after SCL falling.
// - Protect pin high blocks every write to the array.
// - Word address is 7 to 11 bits; bits above eight come from page bits.
module ees_target
   import ees_pkg::*;
#(
   parameter int SIZE_SEL    = `EES_SIZE_16K,
   parameter int PROG_CYCLES = `EES_PROG_TIME_MS * (`EES_CLK_HZ / 1000)
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic scl,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe,
   input  wire logic select_pin_high,
   input  wire logic select_pin_mid,
   input  wire logic select_pin_low,
   input  wire logic write_protect,
   output logic      standby
);

   localparam int PCW = $clog2(PROG_CYCLES + 1);
   localparam int PAGE_BITS = (SIZE_SEL > 1) ? SIZE_SEL - 1 : 0;
   localparam logic [`EES_MAX_AW-1:0] AMASK =
      `EES_MAX_AW'((1 << (`EES_BASE_AW + SIZE_SEL)) - 1);
   localparam logic [`EES_MAX_AW-1:0] PMASK =
      (SIZE_SEL < 2) ? `EES_PAGE8_MASK : `EES_PAGE16_MASK;

   logic [`EES_SYNC_W-1:0] sync1;
   logic [`EES_SYNC_W-1:0] sync2;
   logic                   scl_q;
   logic                   sda_q;
   logic                   scl_s;
   logic                   sda_s;
   logic                   wp_s;
   logic [2:0]             sel_s;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_det;
   logic                   stop_det;

   ees_state_e             state;
   logic [3:0]             bitcnt;
   logic [7:0]             shreg;
   logic [2:0]             dev_page;
   logic                   dev_rw;
   logic                   rd_ack;
   logic                   wr_pend;
   logic [`EES_MAX_AW-1:0] addr_cnt;
   logic                   commit_pend;
   logic                   prog_busy;
   logic [PCW-1:0]         prog_cnt;

   ees_state_e             next_state;
   logic [3:0]             next_bitcnt;
   logic [7:0]             next_shreg;
   logic [2:0]             next_dev_page;
   logic                   next_dev_rw;
   logic                   next_rd_ack;
   logic                   next_wr_pend;
   logic [`EES_MAX_AW-1:0] next_addr;
   logic                   next_commit;
   logic                   next_busy;
   logic [PCW-1:0]         next_pcnt;
   logic                   next_oe;
   logic                   next_standby;

   logic                   dev_hit;
   logic [7:0]             mem_rd;
   logic                   push;
   logic                   buf_in_ready;
   logic                   buf_out_valid;
   logic                   buf_out_ready;
   ees_wr_word_s           push_word;
   ees_wr_word_s           pop_word;
   logic                   prog_done;

   logic [7:0]             mem [`EES_MEM_BYTES];
   logic [`EES_MAX_AW-1:0] lat_addr [`EES_LAT_DEPTH];
   logic [7:0]             lat_data [`EES_LAT_DEPTH];
   logic [`EES_LAT_DEPTH-1:0] lat_vld;

   // The third stage reads only the second flop, so edges are seen on settled levels.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 6'h3f;
         sync2 <= 6'h3f;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         sync1 <= {write_protect, select_pin_high, select_pin_mid, select_pin_low, sda_i, scl};
         sync2 <= sync1;
         scl_q <= sync2[0];
         sda_q <= sync2[1];
      end
   end

   assign scl_s     = sync2[0];
   assign sda_s     = sync2[1];
   assign sel_s     = sync2[4:2];
   assign wp_s      = sync2[5];
   assign scl_rise  = scl_s && !scl_q;
   assign scl_fall  = !scl_s && scl_q;
   assign start_det = scl_s && scl_q && sda_q && !sda_s;
   assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
   assign sda_o     = 1'b0;
   assign mem_rd    = mem[addr_cnt];
   assign prog_done = prog_busy && (prog_cnt == '0);
   assign push_word = '{addr: addr_cnt, data: shreg};

   always_comb begin
      dev_hit = (shreg[7:4] == `EES_DEV_TYPE) && !prog_busy && !commit_pend;
      for (int i = 0; i < 3; i++) begin
         if (i >= PAGE_BITS && shreg[i+1] != sel_s[i]) begin
            dev_hit = 1'b0;
         end
      end
   end

   always_comb begin
      next_state    = state;
      next_bitcnt   = bitcnt;
      next_shreg    = shreg;
      next_dev_page = dev_page;
      next_dev_rw   = dev_rw;
      next_rd_ack   = rd_ack;
      next_wr_pend  = wr_pend;
      next_addr     = addr_cnt;
      next_commit   = commit_pend;
      next_busy     = prog_busy;
      next_pcnt     = prog_cnt;
      next_oe       = sda_oe;
      push          = 1'b0;
      // Programming waits for the buffer to empty so the last byte is in the latch.
      if (commit_pend && !buf_out_valid) begin
         next_commit = 1'b0;
         next_busy   = 1'b1;
         next_pcnt   = PCW'(PROG_CYCLES - 1);
      end else if (prog_busy) begin
         if (prog_cnt == '0) begin
            next_busy = 1'b0;
         end else begin
            next_pcnt = prog_cnt - PCW'(1);
         end
      end
      if (start_det) begin
         next_state   = ST_DEV;
         next_bitcnt  = 4'h0;
         next_oe      = 1'b0;
         next_wr_pend = 1'b0;
      end else if (stop_det) begin
         next_state   = ST_IDLE;
         next_oe      = 1'b0;
         next_wr_pend = 1'b0;
         if (wr_pend && !wp_s) begin
            next_commit = 1'b1;
         end
      end else if (scl_rise) begin
         case (state)
            ST_DEV, ST_WADDR, ST_WDATA: begin
               next_shreg  = {shreg[6:0], sda_s};
               next_bitcnt = bitcnt + 4'h1;
            end
            ST_RDATA: begin
               next_bitcnt = bitcnt + 4'h1;
            end
            ST_RACK: begin
               next_rd_ack = !sda_s;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state)
            ST_DEV: begin
               if (bitcnt == `EES_BYTE_DONE) begin
                  if (dev_hit) begin
                     next_state    = ST_DEV_ACK;
                     next_oe       = 1'b1;
                     next_dev_rw   = shreg[0];
                     next_dev_page = shreg[3:1];
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_DEV_ACK: begin
               if (dev_rw) begin
                  next_state  = ST_RDATA;
                  next_shreg  = mem_rd;
                  next_oe     = !mem_rd[7];
                  next_bitcnt = 4'h0;
               end else begin
                  next_state  = ST_WADDR;
                  next_oe     = 1'b0;
                  next_bitcnt = 4'h0;
               end
            end
            ST_WADDR: begin
               if (bitcnt == `EES_BYTE_DONE) begin
                  next_addr  = {dev_page, shreg} & AMASK;
                  next_state = ST_WADDR_ACK;
                  next_oe    = 1'b1;
               end
            end
            ST_WDATA: begin
               if (bitcnt == `EES_BYTE_DONE) begin
                  // A full buffer withholds the acknowledge and drops the byte, returning to idle.
                  if (buf_in_ready) begin
                     push         = 1'b1;
                     next_wr_pend = 1'b1;
                     next_addr    = (addr_cnt & ~PMASK) | ((addr_cnt + 11'h001) & PMASK);
                     next_state   = ST_WDATA_ACK;
                     next_oe      = 1'b1;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_WADDR_ACK, ST_WDATA_ACK: begin
               next_state  = ST_WDATA;
               next_oe     = 1'b0;
               next_bitcnt = 4'h0;
            end
            ST_RDATA: begin
               if (bitcnt == `EES_BYTE_DONE) begin
                  next_state  = ST_RACK;
                  next_oe     = 1'b0;
                  next_rd_ack = 1'b0;
                  next_addr   = (addr_cnt + 11'h001) & AMASK;
               end else begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_oe    = !shreg[6];
               end
            end
            ST_RACK: begin
               if (rd_ack) begin
                  next_state  = ST_RDATA;
                  next_shreg  = mem_rd;
                  next_oe     = !mem_rd[7];
                  next_bitcnt = 4'h0;
               end else begin
                  next_state = ST_IDLE;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
      next_standby = (next_state == ST_IDLE) && !next_busy && !next_commit;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state       <= ST_IDLE;
         bitcnt      <= 4'h0;
         shreg       <= 8'h00;
         dev_page    <= 3'h0;
         dev_rw      <= 1'b0;
         rd_ack      <= 1'b0;
         wr_pend     <= 1'b0;
         addr_cnt    <= 11'h000;
         commit_pend <= 1'b0;
         prog_busy   <= 1'b0;
         prog_cnt    <= '0;
         sda_oe      <= 1'b0;
         standby     <= 1'b1;
      end else begin
         state       <= next_state;
         bitcnt      <= next_bitcnt;
         shreg       <= next_shreg;
         dev_page    <= next_dev_page;
         dev_rw      <= next_dev_rw;
         rd_ack      <= next_rd_ack;
         wr_pend     <= next_wr_pend;
         addr_cnt    <= next_addr;
         commit_pend <= next_commit;
         prog_busy   <= next_busy;
         prog_cnt    <= next_pcnt;
         sda_oe      <= next_oe;
         standby     <= next_standby;
      end
   end

   // Draining stops while the array programs, so a byte never lands in a latch being written.
   assign buf_out_ready = !prog_busy;

   ees_buf2 #(
      .W($bits(ees_wr_word_s))
   ) u_wbuf (
      .clk      (clk),
      .arst_n   (arst_n),
      .in_valid (push),
      .in_ready (buf_in_ready),
      .in_data  (push_word),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data (pop_word)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lat_vld <= '0;
      end else begin
         // A start or stop seen while programming must not discard the page being written.
         if (prog_done || (!prog_busy && !commit_pend && (start_det || (stop_det && wp_s)))) begin
            lat_vld <= '0;
         end
         if (buf_out_valid && buf_out_ready) begin
            lat_vld[pop_word.addr[3:0] & PMASK[3:0]] <= 1'b1;
         end
      end
   end

   // The array and latch hold data only, so they carry no reset, as nonvolatile content would.
   always_ff @(posedge clk) begin
      if (buf_out_valid && buf_out_ready) begin
         lat_addr[pop_word.addr[3:0] & PMASK[3:0]] <= pop_word.addr;
         lat_data[pop_word.addr[3:0] & PMASK[3:0]] <= pop_word.data;
      end
      if (prog_done) begin
         for (int i = 0; i < `EES_LAT_DEPTH; i++) begin
            if (lat_vld[i]) begin
               mem[lat_addr[i]] <= lat_data[i];
            end
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_byte_in_done;
      (state == ST_WADDR || state == ST_WDATA) && scl_fall && bitcnt == `EES_BYTE_DONE
         && !start_det && !stop_det && (state == ST_WADDR || buf_in_ready);
   endsequence

   sequence s_ack_held;
      sda_oe && !scl_fall;
   endsequence

   chk_start_enters: assert property (start_det |=> state == ST_DEV && !sda_oe)
      else $error("start did not open a device address phase");
   chk_stop_ends: assert property (stop_det && !start_det |=> state == ST_IDLE && !sda_oe)
      else $error("stop did not end the transfer");
   chk_ack_drive: assert property (s_byte_in_done |=> sda_oe ##1 s_ack_held[*2])
      else $error("received byte not acknowledged low");
   chk_oe_after_fall: assert property ($changed(sda_oe) |-> $past(scl_fall)
      || $past(stop_det) || $past(start_det))
      else $error("SDA output changed outside a falling SCL edge");
   chk_dev_miss: assert property (state == ST_DEV && scl_fall && bitcnt == `EES_BYTE_DONE
      && !dev_hit && !start_det && !stop_det |=> state == ST_IDLE && !sda_oe)
      else $error("mismatched address word not released");
   chk_busy_silent: assert property (state == ST_DEV && scl_fall && (prog_busy || commit_pend)
      |=> state != ST_DEV_ACK)
      else $error("address acknowledged during programming");
   chk_prog_length: assert property (prog_busy && prog_cnt != '0 |=> prog_busy)
      else $error("programming ended early");
   chk_prog_end: assert property ($fell(prog_busy) |-> $past(prog_cnt) == '0)
      else $error("programming ended without a full count");
   chk_latch_hold: assert property (prog_busy && prog_cnt != '0 |=> lat_vld == $past(lat_vld))
      else $error("page latch changed while programming");
   chk_wp_skip: assert property (stop_det && wp_s && !commit_pend |=> !commit_pend[*3])
      else $error("protected write started programming");
   chk_page_wrap: assert property (state == ST_WDATA && scl_fall && bitcnt == `EES_BYTE_DONE
      && buf_in_ready && !start_det && !stop_det
      |=> (addr_cnt & ~PMASK) == ($past(addr_cnt) & ~PMASK))
      else $error("write address left its page");
   chk_read_wrap: assert property (state == ST_RDATA && scl_fall && bitcnt == `EES_BYTE_DONE
      && !start_det && !stop_det |=> addr_cnt == (($past(addr_cnt) + 11'h001) & AMASK))
      else $error("read address did not advance over the whole array");

endmodule // ees_target

// file: sim/ees_ctl_model.sv
// Bus controller model for the EEPROM target: drives SCL and pulls SDA low.
// Assumes the bench resolves SDA from both pull-down enables with a pull-up.
`timescale 1ns/1ps

module ees_ctl_model (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      m_oe
);
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // SCL stands high between frames, so the target sees no clock while idle.
   task automatic start();
      m_oe <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(4);
      m_oe <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask

   task automatic stop();
      m_oe <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(4);
      m_oe <= 1'b0;
      tick(4);
   endtask

   // The long low phase leaves the target time to drive before the sample.
   task automatic bit_x(input logic b, output logic r);
      tick(1);
      m_oe <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(2);
      r = sda;
      tick(1);
      scl <= 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(~ack, r);
   endtask

   task automatic recover();
      logic r;
      for (int i = 0; i < 9; i++) begin
         bit_x(1'b1, r);
         if (r === 1'b1) break;
      end
      start();
   endtask
endmodule // ees_ctl_model

// file: sim/ees_target_test.sv
// Self-checking bench for the EEPROM target, built as the 1K size with 8-byte pages.
// Assumes the controller model and an SDA pull-up resolved here.
`timescale 1ns/1ps
`include "ees_params.svh"

module ees_target_test;
   localparam logic [2:0] SEL = 3'h5;
   logic clk;
   logic arst_n;
   logic scl;
   logic m_oe;
   logic sda_o;
   logic sda_oe;
   logic wp;
   logic standby;
   wire  sda = ~(sda_oe | m_oe);
   int   n_fail = 0;
   int   samples_checked = 0;
   int   cycles = 0;

   ees_target #(.SIZE_SEL(0), .PROG_CYCLES(400)) ees_target_i (
      .clk(clk), .arst_n(arst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .select_pin_high(SEL[2]), .select_pin_mid(SEL[1]),
      .select_pin_low(SEL[0]), .write_protect(wp), .standby(standby));
   ees_ctl_model ees_ctl_model_i (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic stop_test();
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hung transfer would otherwise stall the run forever.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic dev(input logic rw, input logic [2:0] s, output logic a);
      ees_ctl_model_i.start();
      ees_ctl_model_i.wr_byte({`EES_DEV_TYPE, s, rw}, a);
   endtask

   task automatic poll();
      logic a;
      int   n;
      n = 0;
      do begin
         dev(1'b0, SEL, a);
         ees_ctl_model_i.stop();
         n++;
      end while (a !== 1'b1 && n < 30);
      check(8'(a), 8'h1);
      check(8'(n > 1), 8'h1);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] base, input int cnt,
                     input logic fin);
      logic a;
      dev(1'b0, SEL, a);
      check(8'(a), 8'h1);
      ees_ctl_model_i.wr_byte(adr, a);
      check(8'(a), 8'h1);
      for (int i = 0; i < cnt; i++) begin
         ees_ctl_model_i.wr_byte(base + 8'(i), a);
         check(8'(a), 8'h1);
      end
      if (fin) ees_ctl_model_i.stop();
      repeat (10) @(posedge clk);
   endtask

   task automatic cur(input logic [7:0] exp[$]);
      logic       a;
      logic [7:0] v;
      dev(1'b1, SEL, a);
      check(8'(a), 8'h1);
      foreach (exp[i]) begin
         ees_ctl_model_i.rd_byte(i < exp.size() - 1, v);
         check(v, exp[i]);
      end
      ees_ctl_model_i.stop();
   endtask

   task automatic rd(input logic [7:0] adr, input logic [7:0] exp[$]);
      logic a;
      dev(1'b0, SEL, a);
      check(8'(a), 8'h1);
      ees_ctl_model_i.wr_byte(adr, a);
      cur(exp);
   endtask

   task automatic t_idle();
      check(8'(standby), 8'h1);
      ees_ctl_model_i.recover();
      ees_ctl_model_i.stop();
      check(8'(sda_oe), 8'h0);
      check(8'(sda_o), 8'h0);
   endtask

   task automatic t_select();
      logic a;
      dev(1'b0, SEL ^ 3'h1, a);
      check(8'(a), 8'h0);
      dev(1'b1, SEL ^ 3'h4, a);
      check(8'(a), 8'h0);
      ees_ctl_model_i.start();
      ees_ctl_model_i.wr_byte(8'hba, a);
      check(8'(a), 8'h0);
      ees_ctl_model_i.stop();
      check(8'(standby), 8'h1);
   endtask

   // Ten bytes from offset six cross the page start once and overwrite offsets six and seven.
   task automatic t_page();
      wr(8'h0e, 8'h10, 10, 1'b1);
      check(8'(standby), 8'h0);
      poll();
      cur('{8'h12});
      rd(8'h0c, '{8'h16, 8'h17, 8'h18, 8'h19});
   endtask

   task automatic t_wrap();
      wr(8'h7f, 8'ha5, 1, 1'b1);
      poll();
      wr(8'h00, 8'h5a, 1, 1'b1);
      poll();
      rd(8'h7f, '{8'ha5, 8'h5a});
   endtask

   task automatic t_protect();
      wp <= 1'b1;
      wr(8'h00, 8'hff, 1, 1'b1);
      check(8'(standby), 8'h1);
      wp <= 1'b0;
      rd(8'h00, '{8'h5a});
   endtask

   // A repeated start in mid write must discard the latched byte.
   task automatic t_abort();
      wr(8'h7f, 8'h11, 1, 1'b0);
      rd(8'h7f, '{8'ha5});
   endtask

   initial begin
      arst_n = 1'b0;
      wp = 1'b0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_idle();
      t_select();
      t_page();
      t_wrap();
      t_protect();
      t_abort();
      stop_test();
   end
endmodule // ees_target_test
